/* File: nsb_pkg.sv */
// Package for the NAND status, signature and boot-read host controller.
// Assumes a 100 MHz system clock and an 8-bit NAND data path.
package nsb_pkg;

    // ----------------------------------------------------------------
    // NAND command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SIGNATURE = 8'h90; // Signature read
    localparam logic [7:0] CMD_STATUS = 8'h70; // Status read
    localparam logic [7:0] CMD_RESET = 8'hff; // Device reset
    localparam logic [7:0] ERASED_BYTE = 8'hff; // Erased cell value

    // ----------------------------------------------------------------
    // Status byte fields
    // ----------------------------------------------------------------
    localparam int SR_WP = 7; // Write protect flag
    localparam int SR_RDY = 6; // Controller ready flag
    localparam int SR_RDY_ALT = 5; // Controller ready flag alt
    localparam int SR_FAIL = 0; // Operation fail flag

    // ----------------------------------------------------------------
    // Bad block marker position
    // ----------------------------------------------------------------
    localparam int BB_SPARE_BYTE = 5; // Sixth spare byte, index from zero
    localparam int PAGE_MAIN_BYTES = 512; // Main area length

    // ----------------------------------------------------------------
    // Host register map (byte address, word index = byte address / 4)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00; // Command register
    localparam logic [7:0] REG_STATUS = 8'h04; // Controller status
    localparam logic [7:0] REG_DATA = 8'h08; // Last read byte
    localparam logic [7:0] REG_SIG = 8'h0c; // Maker and device code
    localparam logic [7:0] REG_NSTAT = 8'h10; // Last NAND status byte

    // Command field in the control write
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_STATUS = 3'h1; // Read status once
    localparam logic [2:0] OP_SIG = 3'h2; // Read signature
    localparam logic [2:0] OP_BOOT = 3'h3; // Read one boot byte
    localparam logic [2:0] OP_STOP = 3'h4; // Stop sequential read
    localparam logic [2:0] OP_BBCHK = 3'h5; // Check bad block marker byte

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100; // System clock rate
    localparam int T_STROBE_NS = 30; // Strobe low/high least time
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000; // Rounded up

    // NAND pins travelling together
    typedef struct packed {
        logic ce_n; // Chip enable
        logic cle; // Command latch
        logic ale; // Address latch
        logic we_n; // Write strobe
        logic re_n; // Read strobe
    } nsb_pins_s;

    // Result of one bus cycle
    typedef struct packed {
        logic done; // Cycle finished
        logic [7:0] data; // Byte sampled on a read
    } nsb_cyc_s;

endpackage

/* File: nsb_sync.sv */
// Two flip-flop synchroniser for pin inputs.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module nsb_sync #(
    parameter int W = 1 // Width of the bus
) (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [W-1:0] d, // Raw pin level
    output logic [W-1:0] q // Synchronised level
);
    logic [W-1:0] meta; // First stage, read only by q
    logic [W-1:0] next_meta; // Next first stage
    logic [W-1:0] next_q; // Next second stage

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    // Register both stages
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

/* File: nsb_cycle.sv */
// One NAND bus cycle engine: a write (command) or a read strobe pulse.
// Assumes synchronised data input and a strobe width from the package.
`timescale 1ns/100ps
`default_nettype none
module nsb_cycle (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic start, // Begin one cycle
    input wire logic is_read, // Read when high, write when low
    input wire logic [7:0] io_in, // Synchronised data pins
    output logic we_n, // Write strobe
    output logic re_n, // Read strobe
    output var nsb_pkg::nsb_cyc_s res // Done pulse and sampled byte
);
    typedef enum logic [1:0] {
        CY_IDLE = 2'b00,
        CY_LOW = 2'b01,
        CY_HIGH = 2'b11
    } nsb_cy_e;

    nsb_cy_e st, next_st; // Phase of the cycle
    logic [7:0] cnt, next_cnt; // Phase timer
    logic rd, next_rd; // Latched direction
    logic next_we_n, next_re_n; // Next strobes
    nsb_pkg::nsb_cyc_s next_res; // Next result

    // ----------------------------------------------------------------
    // Phase sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_rd = rd;
        next_we_n = we_n;
        next_re_n = re_n;
        next_res = res;
        next_res.done = 1'b0;
        unique case (st)
            CY_IDLE: begin
                if (start) begin // Drive strobe low
                    next_st = CY_LOW;
                    next_rd = is_read;
                    next_cnt = 8'(nsb_pkg::STROBE_CYC);
                    next_we_n = is_read;
                    next_re_n = !is_read;
                end
            end
            CY_LOW: begin
                if (cnt == 8'h00) begin // Sample then release strobe
                    next_st = CY_HIGH;
                    next_cnt = 8'(nsb_pkg::STROBE_CYC);
                    next_we_n = 1'b1;
                    next_re_n = 1'b1;
                    if (rd) begin
                        next_res.data = io_in;
                    end
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            CY_HIGH: begin
                if (cnt == 8'h00) begin // Hold high time, then report
                    next_st = CY_IDLE;
                    next_res.done = 1'b1;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            default: begin
                next_st = CY_IDLE;
            end
        endcase
    end

    // Register phase state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= CY_IDLE;
            cnt <= 8'h00;
            rd <= 1'b0;
            we_n <= 1'b1;
            re_n <= 1'b1;
            res <= '0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            rd <= next_rd;
            we_n <= next_we_n;
            re_n <= next_re_n;
            res <= next_res;
        end
    end
endmodule
`default_nettype wire

/* File: nsb_host.sv */
// Host controller for NAND status, signature read and power-up boot read.
// Assumes software on a plain strobe port and a NAND on its pins.
// Summary of operation
// [R1] Status bits six, five: one means ready
// [R2] Status bit zero: last operation failed
// [R3] Status bit seven: zero means write protected
// [R4] Status bits four to two ignored
// [R5] Command 90h starts signature read
// [R6] Reads return maker then device code
// [R7] Device resets outputs at supply threshold
// [R8] Page 0 readable after power-up, no commands
// [R9] Busy low during array load time
// [R10] One buffer byte per read strobe
// [R11] Sequential off: only page 0 loaded
// [R12] Sequential on: pages advance after load
// [R13] CE high or command stops sequential
// [R14] Valid blocks delivered erased, FFh
// [R15] Sixth spare byte not FFh: bad
// [R16] Record bad markers before any erase
// [R17] Failed program or erase: newly bad
// [R18] Failed program keeps other pages
// [R19] Erase fail replace; read errors ECC
// [R20] Status mode repeats until new command
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module nsb_host (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [7:0] bus_addr, // Register byte address
    input wire logic [31:0] bus_wdata, // Write data
    input wire logic bus_wr, // Write strobe
    input wire logic bus_rd, // Read strobe
    output logic [31:0] bus_rdata, // Read data, one cycle later
    input wire logic nand_rb, // Ready/busy pin, low when busy
    input wire logic [7:0] nand_io_in, // Data pins in
    output logic [7:0] nand_io_out, // Data pins out
    output logic nand_io_oe, // High while host drives data pins
    output var nsb_pkg::nsb_pins_s nand_pins // Control pins
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000, // Waiting for an order
        HS_CMD = 3'b001, // Command write cycle running
        HS_READ = 3'b011, // Read cycle running
        HS_WAIT = 3'b010, // Waiting for ready
        HS_DONE = 3'b110 // Result capture
    } nsb_hs_e;

    nsb_hs_e st, next_st; // Sequencer state
    logic [2:0] op, next_op; // Order in progress
    logic [7:0] io_s; // Synchronised data pins
    logic rb_s; // Synchronised ready/busy
    logic cyc_start, cyc_is_read; // Cycle engine request
    logic cyc_we_n, cyc_re_n; // Cycle engine strobes
    nsb_pkg::nsb_cyc_s cyc_res; // Cycle engine result
    logic [7:0] next_io_out; // Next data pins
    logic next_io_oe; // Next drive enable
    nsb_pkg::nsb_pins_s next_pins; // Next control pins
    logic [7:0] cur_cmd, next_cur_cmd; // Last command written
    logic [7:0] data, next_data; // Last byte read
    logic [7:0] nstat, next_nstat; // Last status byte
    logic [7:0] maker, next_maker; // Maker code
    logic [7:0] dev, next_dev; // Device code
    logic sig_idx, next_sig_idx; // Which signature byte next
    logic seq_run, next_seq_run; // Sequential boot read alive
    logic bad, next_bad; // Marker check result
    logic fail_seen, next_fail_seen; // Sticky newly bad block
    logic rb_prev, next_rb_prev; // Ready level last cycle
    logic [15:0] loads, next_loads; // Page loads seen
    logic [31:0] next_rdata; // Next read data

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    nsb_sync #(.W(8)) u_sync_io (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d(nand_io_in),
        .q(io_s)
    );

    nsb_sync #(.W(1)) u_sync_rb (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d(nand_rb),
        .q(rb_s)
    );

    // ----------------------------------------------------------------
    // Bus cycle engine
    // ----------------------------------------------------------------
    nsb_cycle u_cycle (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .start(cyc_start),
        .is_read(cyc_is_read),
        .io_in(io_s),
        .we_n(cyc_we_n),
        .re_n(cyc_re_n),
        .res(cyc_res)
    );

    // ----------------------------------------------------------------
    // Sequencer: next values
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_op = op;
        next_cur_cmd = cur_cmd;
        next_data = data;
        next_nstat = nstat;
        next_maker = maker;
        next_dev = dev;
        next_sig_idx = sig_idx;
        next_seq_run = seq_run;
        next_bad = bad;
        next_fail_seen = fail_seen;
        next_rb_prev = rb_s;
        next_loads = loads;
        next_io_out = nand_io_out;
        next_io_oe = 1'b0;
        next_pins = nand_pins;
        next_pins.we_n = cyc_we_n;
        next_pins.re_n = cyc_re_n;
        cyc_start = 1'b0;
        cyc_is_read = 1'b0;
        // Count each page load end seen on ready/busy
        if (rb_s && !rb_prev) begin
            next_loads = loads + 16'h0001; // R9 R12
        end
        unique case (st)
            HS_IDLE: begin
                next_pins.cle = 1'b0;
                next_pins.ale = 1'b0;
                if (bus_wr && bus_addr == nsb_pkg::REG_CTRL) begin
                    next_op = bus_wdata[2:0];
                    next_pins.ce_n = 1'b0;
                    unique case (bus_wdata[2:0])
                        nsb_pkg::OP_STATUS: begin
                            // Issue only if not already in status mode
                            if (cur_cmd == nsb_pkg::CMD_STATUS) begin
                                next_st = HS_WAIT; // R20
                            end else begin
                                next_cur_cmd = nsb_pkg::CMD_STATUS;
                                next_st = HS_CMD;
                            end
                        end
                        nsb_pkg::OP_SIG: begin
                            if (cur_cmd != nsb_pkg::CMD_SIGNATURE) begin
                                next_cur_cmd = nsb_pkg::CMD_SIGNATURE; // R5
                                next_sig_idx = 1'b0;
                                next_st = HS_CMD;
                            end else begin
                                next_st = HS_WAIT; // R6
                            end
                        end
                        nsb_pkg::OP_BOOT, nsb_pkg::OP_BBCHK: begin
                            next_st = HS_WAIT; // R8 R10
                        end
                        nsb_pkg::OP_STOP: begin
                            next_pins.ce_n = 1'b1; // R13
                            next_seq_run = 1'b0;
                            next_st = HS_IDLE;
                        end
                        default: begin
                            next_st = HS_IDLE;
                        end
                    endcase
                end
            end
            HS_CMD: begin
                // One command write, latch high, data driven
                next_pins.cle = 1'b1;
                next_io_out = cur_cmd;
                next_io_oe = 1'b1;
                next_seq_run = 1'b0; // R13
                cyc_start = (cyc_we_n && cyc_re_n && !cyc_res.done && nand_pins.cle);
                if (cyc_res.done) begin
                    next_pins.cle = 1'b0;
                    next_io_oe = 1'b0;
                    next_st = HS_WAIT;
                end
            end
            HS_WAIT: begin
                // Hold off read strobes while the array loads
                if (rb_s) begin // R9 R11
                    cyc_start = 1'b1;
                    cyc_is_read = 1'b1;
                    next_st = HS_READ;
                end
            end
            HS_READ: begin
                if (cyc_res.done) begin
                    next_data = cyc_res.data; // R10
                    next_st = HS_DONE;
                end
            end
            HS_DONE: begin
                unique case (op)
                    nsb_pkg::OP_STATUS: begin
                        next_nstat = data; // R1 R2 R3 R4
                        // A failed program or erase marks the block bad
                        if (data[nsb_pkg::SR_FAIL]) begin
                            next_fail_seen = 1'b1; // R17 R19
                        end
                    end
                    nsb_pkg::OP_SIG: begin
                        if (!sig_idx) begin
                            next_maker = data; // R6
                        end else begin
                            next_dev = data; // R6
                        end
                        next_sig_idx = !sig_idx;
                    end
                    nsb_pkg::OP_BBCHK: begin
                        next_bad = (data != nsb_pkg::ERASED_BYTE); // R15 R16
                    end
                    default: begin
                        next_seq_run = 1'b1; // R12
                    end
                endcase
                next_st = HS_IDLE;
            end
            default: begin
                next_st = HS_IDLE;
            end
        endcase
        // Clear of the sticky flag loses to a new failure
        if (bus_wr && bus_addr == nsb_pkg::REG_STATUS && bus_wdata[0]
            && !(st == HS_DONE && op == nsb_pkg::OP_STATUS && data[nsb_pkg::SR_FAIL])) begin
            next_fail_seen = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register read mux
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (bus_rd) begin
            unique case (bus_addr)
                nsb_pkg::REG_CTRL: next_rdata = {29'h0, op};
                nsb_pkg::REG_STATUS: begin
                    next_rdata = {loads, 11'h000, bad, seq_run, rb_s,
                        (st == HS_IDLE), fail_seen};
                end
                nsb_pkg::REG_DATA: next_rdata = {24'h0, data};
                nsb_pkg::REG_SIG: next_rdata = {16'h0, maker, dev};
                nsb_pkg::REG_NSTAT: begin
                    // Reserved bits masked; ready from both flags
                    next_rdata = {24'h0, nstat[nsb_pkg::SR_WP],
                        nstat[nsb_pkg::SR_RDY] & nstat[nsb_pkg::SR_RDY_ALT],
                        5'h00, nstat[nsb_pkg::SR_FAIL]}; // R1 R3 R4
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= HS_IDLE;
            op <= nsb_pkg::OP_NONE;
            cur_cmd <= nsb_pkg::CMD_RESET;
            data <= 8'h00;
            nstat <= 8'h00;
            maker <= 8'h00;
            dev <= 8'h00;
            sig_idx <= 1'b0;
            seq_run <= 1'b0;
            bad <= 1'b0;
            fail_seen <= 1'b0;
            rb_prev <= 1'b0;
            loads <= 16'h0000;
            nand_io_out <= 8'h00;
            nand_io_oe <= 1'b0;
            nand_pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1};
            bus_rdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
            op <= next_op;
            cur_cmd <= next_cur_cmd;
            data <= next_data;
            nstat <= next_nstat;
            maker <= next_maker;
            dev <= next_dev;
            sig_idx <= next_sig_idx;
            seq_run <= next_seq_run;
            bad <= next_bad;
            fail_seen <= next_fail_seen;
            rb_prev <= next_rb_prev;
            loads <= next_loads;
            nand_io_out <= next_io_out;
            nand_io_oe <= next_io_oe;
            nand_pins <= next_pins;
            bus_rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: nsb_nand_model.sv */
// Behavioural NAND device: status, signature and power-up boot read.
// Assumes host pins from nsb_host and a resolved data bus.
`timescale 1ns/100ps
`default_nettype none
module nsb_nand_model #(
    parameter int LOAD = 20, // Array load busy cycles, shortened
    parameter int PG = 4, // Bytes per page, shortened
    parameter bit SEQ = 1'b1, // Sequential row read option
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary maker code
    parameter logic [7:0] DEV = 8'hc3 // Arbitrary device code
) (
    input wire logic clk, // Timer clock
    input wire nsb_pkg::nsb_pins_s p, // Host control pins
    input wire logic [7:0] io, // Resolved data bus
    input wire logic wp_n, // Low when write protected
    input wire logic fail, // Last program or erase failed
    output logic rb, // Low while busy
    output logic [7:0] q // Data towards host
);
    int mode = 0; // 0 boot, 1 status, 2 signature, 3 other
    int idx = 0; // Byte within page or code
    int pg = 0; // Boot page
    int busy = LOAD; // Power-up load countdown
    logic [7:0] d; // Byte on offer
    logic [7:0] last = 8'h00; // Last byte handed out
    assign rb = (busy == 0);
    always @(posedge clk) if (busy > 0) busy <= busy - 1;
    // Command latch on write strobe rise
    always @(posedge p.we_n) if (!p.ce_n && p.cle) begin
        mode <= (io == 8'h90) ? 2 : (io == 8'h70) ? 1 : 3;
        idx <= 0;
    end
    // Chip enable high ends the boot stream
    always @(posedge p.ce_n) if (mode == 0 && rb) mode <= 3;
    // Offered byte; status follows live inputs
    always_comb case (mode)
        0: d = {pg[3:0], idx[3:0]};
        1: d = {wp_n, rb, rb, 3'b101, 1'b0, fail};
        2: d = (idx == 0) ? MAKER : DEV;
        default: d = 8'hff;
    endcase
    // Released bus shows the inverse of the last byte
    assign q = (!p.ce_n && !p.re_n) ? d : ~last;
    // Advance per read strobe; next page after a load time
    always @(posedge p.re_n) if (!p.ce_n) begin
        last <= d;
        idx <= idx + 1;
        if (SEQ && mode == 0 && idx == PG - 1) begin
            idx <= 0;
            pg <= pg + 1;
            busy <= LOAD;
        end
    end
endmodule
`default_nettype wire

/* File: nsb_host_asserts.sv */
// Checker for the NAND host pins and register port.
// Assumes one clock domain; bound onto nsb_host.
`timescale 1ns/100ps
`default_nettype none
module nsb_host_asserts (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic nand_rb,
    input wire logic [7:0] nand_io_in,
    input wire logic [7:0] nand_io_out,
    input wire logic nand_io_oe,
    input wire nsb_pkg::nsb_pins_s nand_pins
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_reset_pins_idle: assert property ($rose(arst_n) |-> nand_pins.ce_n
        && nand_pins.we_n && nand_pins.re_n && !nand_io_oe) else $error("pins busy after reset");
    a_strobe_excl: assert property (!(!nand_pins.we_n && !nand_pins.re_n))
        else $error("both strobes low");
    a_cmd_latch: assert property ($fell(nand_pins.we_n) |-> nand_pins.cle
        && nand_io_oe && !nand_pins.ce_n) else $error("command cycle malformed");
    a_cmd_width: assert property ($fell(nand_pins.we_n) |-> (!nand_pins.we_n)[*3])
        else $error("write strobe too short");
    a_io_held: assert property (!nand_pins.we_n |-> nand_io_oe && $stable(nand_io_out))
        else $error("data moved under write strobe");
    a_read_width: assert property ($fell(nand_pins.re_n) |-> (!nand_pins.re_n)[*3])
        else $error("read strobe too short");
    a_read_no_drive: assert property (!nand_pins.re_n |-> !nand_io_oe)
        else $error("host drives bus in read");
    a_busy_blocks: assert property (!nand_rb && $past(!nand_rb) && $past(!nand_rb, 2)
        && $past(!nand_rb, 3) |-> !$fell(nand_pins.re_n)) else $error("read while busy");
    a_ce_after_cmd: assert property ($fell(nand_pins.ce_n) |-> $past(bus_wr)
        || $past(bus_wr, 2)) else $error("chip enable without order");
    a_nstat_reserved: assert property ($past(bus_rd) && $past(bus_addr) == nsb_pkg::REG_NSTAT
        |-> bus_rdata[4:1] == 4'h0) else $error("reserved status bits set");
endmodule
bind nsb_host nsb_host_asserts u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .nand_rb(nand_rb), .nand_io_in(nand_io_in),
    .nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe), .nand_pins(nand_pins));
`default_nettype wire

/* File: nsb_host_bench.sv */
// Self-checking bench for the NAND host controller.
// Assumes nsb_host, the device model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module nsb_host_bench;
    localparam int PG = 4; // Model page length
    localparam int LOADS = (PG + 1) / PG + 1; // Boot page loads
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary maker code
    localparam logic [7:0] DEV = 8'hc3; // Arbitrary device code
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic wp_n = 1'b1;
    logic fail = 1'b0;
    logic [31:0] bus_rdata, v;
    logic nand_rb, oe;
    logic [7:0] io_out, mq, io;
    nsb_pkg::nsb_pins_s pins;
    int failures = 0;
    int checks_done = 0;
    always #5 sys_clk = ~sys_clk;
    assign io = oe ? io_out : mq; // Resolved data bus
    nsb_host u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .nand_rb(nand_rb), .nand_io_in(io), .nand_io_out(io_out), .nand_io_oe(oe),
        .nand_pins(pins));
    nsb_nand_model #(.PG(PG), .MAKER(MAKER), .DEV(DEV)) u_nand (.clk(sys_clk), .p(pins),
        .io(io), .wp_n(wp_n), .fail(fail), .rb(nand_rb), .q(mq));
    task automatic end_of_test;
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One register cycle, write or read
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge sys_clk);
        bus_wr <= w;
        bus_rd <= !w;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        #1 r = bus_rdata;
    endtask
    // Order an operation and poll until idle
    task automatic op(input logic [2:0] c);
        logic [31:0] r;
        int n;
        n = 0;
        xfer(1'b1, nsb_pkg::REG_CTRL, {29'($urandom()), c}, r);
        while (r[1] !== 1'b1 && n < 500) begin
            xfer(1'b0, nsb_pkg::REG_STATUS, 32'h0, r);
            n++;
        end
        chk({31'h0, r[1]}, 32'h1);
    endtask
    function automatic logic [31:0] boot_byte(input int k);
        return {24'h0, 4'(k / PG), 4'(k % PG)};
    endfunction
    initial begin
        v = 32'h0;
        void'($urandom(32'h0aa41f7d));
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        // Boot stream across a page boundary
        for (int k = 0; k < PG + 2; k++) begin
            op(nsb_pkg::OP_BOOT);
            xfer(1'b0, nsb_pkg::REG_DATA, 32'h0, v);
            chk({24'h0, v[7:0]}, boot_byte(k));
        end
        xfer(1'b0, nsb_pkg::REG_STATUS, 32'h0, v);
        chk(v, {16'(LOADS), 16'h000e});
        // Status flags, changing while status mode stays
        for (int i = 0; i < 4; i++) begin
            wp_n = (i == 0) ? 1'b0 : 1'($urandom());
            fail = (i == 0) ? 1'b1 : 1'($urandom());
            op(nsb_pkg::OP_STATUS);
            xfer(1'b0, nsb_pkg::REG_NSTAT, 32'h0, v);
            chk(v, {24'h0, wp_n, 1'b1, 5'h00, fail});
        end
        xfer(1'b0, nsb_pkg::REG_STATUS, 32'h0, v);
        chk(v, {16'(LOADS), 16'h0007});
        xfer(1'b1, nsb_pkg::REG_STATUS, 32'h1, v);
        xfer(1'b0, nsb_pkg::REG_STATUS, 32'h0, v);
        chk(v, {16'(LOADS), 16'h0006});
        op(nsb_pkg::OP_SIG);
        op(nsb_pkg::OP_SIG);
        xfer(1'b0, nsb_pkg::REG_SIG, 32'h0, v);
        chk({16'h0, v[15:0]}, {16'h0, MAKER, DEV});
        op(nsb_pkg::OP_BBCHK);
        xfer(1'b0, nsb_pkg::REG_STATUS, 32'h0, v);
        chk(v, {16'(LOADS), 16'h0016});
        op(nsb_pkg::OP_STOP);
        chk({31'h0, pins.ce_n}, 32'h1);
        xfer(1'b0, 8'h40, 32'h0, v);
        chk(v, 32'h0);
        end_of_test;
    end
    // Watchdog
    initial begin
        repeat (50000) @(posedge sys_clk);
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire
